// file: rtl/ptp_slice_defines.svh
// Contract
// - A 4-bit expected message version sits in bits 11:8, resets to 0x2, and matching messages are captured.
// - Received PTP packets whose version differs from the expected version are dropped.
// - An 8-bit expected domain sits in bits 7:0, resets to 0x00, and with domain checking on only matching messages are captured.
// - With domain checking off the message domain is ignored for capture and forwarding.
// - Accesses in the window 0x052c to 0x05b3 go to the pin, stamp unit and trigger unit chosen by the index.
// - Index bit 16 picks the second pin when one and the first when zero, resetting to zero.
// - Index bit 8 picks stamp unit 1 when one and unit 0 when zero, resetting to zero.
// - Index bits 1:0 pick trigger unit 0, 1 or 2, code 11 is reserved, resetting to 00.
// - A trigger unit whose time is earlier than system time with notify on sets its error bit in 18:16 and interrupts.
// - Driving a unit's trigger enable to zero clears its error bit.
// - A trigger unit that fires with notify on sets its done bit in 2:0, interrupts, and a written one clears it.
`ifndef PTP_SLICE_DEFINES_SVH
`define PTP_SLICE_DEFINES_SVH
`define ADDR_DOMAIN_VERSION 12'h518
`define ADDR_UNIT_INDEX     12'h520
`define ADDR_TRIG_STATUS    12'h524
`define ADDR_IRQ_MASK       12'h600
`define ADDR_WIN_LO         12'h52c
`define ADDR_WIN_HI         12'h5b3
`define RST_VERSION         4'h2
`define RST_DOMAIN          8'h00
`define DV_WMASK            32'h0000_0fff
`define IDX_WMASK           32'h000f_0f03
`define TRIG_CODE_RSVD      2'h3
`define DV_VER_HI           11
`define DV_VER_LO           8
`define DV_DOM_HI           7
`define DV_DOM_LO           0
`define IDX_PIN_BIT         16
`define IDX_STAMP_BIT       8
`define IDX_TRIG_HI         1
`define IDX_TRIG_LO         0
`define ST_ERR_HI           18
`define ST_ERR_LO           16
`define ST_DONE_HI          2
`define ST_DONE_LO          0
`endif

// file: rtl/ptp_slice_pkg.sv
package ptp_slice_pkg;
    typedef struct packed {
        logic [3:0]  version;
        logic [7:0]  domain;
        logic        check_domain;
        logic        valid;
    } ptp_msg_t;
    typedef struct packed {
        logic        pin_sel;
        logic        stamp_sel;
        logic [1:0]  trig_sel;
        logic        trig_valid;
    } unit_sel_t;
endpackage

// file: rtl/ptp_filter_unit_index_trigger_status.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "ptp_slice_defines.svh"
module ptp_filter_unit_index_trigger_status #(
    parameter int ADDR_W  = 12,
    parameter int N_TRIG  = 3
) (
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic [ADDR_W-1:0]         addr,
    input  wire logic [31:0]               wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic [31:0]                    rdata,
    input  wire ptp_slice_pkg::ptp_msg_t   rx_msg,
    output logic                           capture_en,
    output logic                           msg_drop,
    input  wire logic [N_TRIG-1:0]         trig_late,
    input  wire logic [N_TRIG-1:0]         trig_fired,
    input  wire logic [N_TRIG-1:0]         trig_notify_enable,
    input  wire logic [N_TRIG-1:0]         trig_enable_cleared,
    output ptp_slice_pkg::unit_sel_t       unit_sel,
    output logic                           win_wr,
    output logic                           win_rd,
    output logic                           irq
);
    initial
    begin
        if (N_TRIG != 3 || ADDR_W < 12)
            $error("unsupported parameters");
    end

    logic [3:0]        exp_version;
    logic [7:0]        exp_domain;
    logic [31:0]       index;
    logic [2:0]        trig_error;
    logic [2:0]        trig_done;
    logic [5:0]        irq_mask;
    logic [31:0]       next_rdata;

    wire logic [11:0]  a12      = addr[11:0];
    wire logic         sel_dv   = (a12 == `ADDR_DOMAIN_VERSION);
    wire logic         sel_idx  = (a12 == `ADDR_UNIT_INDEX);
    wire logic         sel_st   = (a12 == `ADDR_TRIG_STATUS);
    wire logic         sel_msk  = (a12 == `ADDR_IRQ_MASK);
    wire logic         in_win   = (a12 >= `ADDR_WIN_LO) && (a12 <= `ADDR_WIN_HI);
    wire logic [31:0]  dv_w     = wdata & `DV_WMASK;
    wire logic [31:0]  idx_w    = wdata & `IDX_WMASK;
    wire logic [2:0]   done_clr = (wr && sel_st) ? wdata[`ST_DONE_HI:`ST_DONE_LO] : 3'h0;
    wire logic [2:0]   err_set  = trig_late & trig_notify_enable;
    wire logic [2:0]   done_set = trig_fired & trig_notify_enable;
    wire logic [5:0]   status   = {trig_error, trig_done};

    // message filtering
    wire logic ver_ok = (rx_msg.version == exp_version);
    wire logic dom_ok = !rx_msg.check_domain || (rx_msg.domain == exp_domain);
    assign capture_en = rx_msg.valid && ver_ok && dom_ok;
    assign msg_drop   = rx_msg.valid && !(ver_ok && dom_ok);

    // window routing
    assign unit_sel.pin_sel    = index[`IDX_PIN_BIT];
    assign unit_sel.stamp_sel  = index[`IDX_STAMP_BIT];
    assign unit_sel.trig_sel   = index[`IDX_TRIG_HI:`IDX_TRIG_LO];
    assign unit_sel.trig_valid = (index[`IDX_TRIG_HI:`IDX_TRIG_LO] != `TRIG_CODE_RSVD);
    assign win_wr = wr && in_win;
    assign win_rd = rd && in_win;

    assign irq = |(status & irq_mask);

    always_comb
    begin
        next_rdata = 32'h0;
        if (sel_dv)
            next_rdata = {20'h0, exp_version, exp_domain};
        else if (sel_idx)
            next_rdata = index;
        else if (sel_st)
            next_rdata = {13'h0, trig_error, 13'h0, trig_done};
        else if (sel_msk)
            next_rdata = {13'h0, irq_mask[5:3], 13'h0, irq_mask[2:0]};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            exp_version <= `RST_VERSION;
            exp_domain  <= `RST_DOMAIN;
            index       <= 32'h0;
            irq_mask    <= 6'h0;
            rdata       <= 32'h0;
        end
        else
        begin
            rdata <= rd ? next_rdata : 32'h0;
            if (wr && sel_dv)
            begin
                exp_version <= dv_w[`DV_VER_HI:`DV_VER_LO];
                exp_domain  <= dv_w[`DV_DOM_HI:`DV_DOM_LO];
            end
            if (wr && sel_idx)
                index <= idx_w;
            if (wr && sel_msk)
                irq_mask <= {wdata[`ST_ERR_HI:`ST_ERR_LO], wdata[`ST_DONE_HI:`ST_DONE_LO]};
        end
    end

    // set wins over clear
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            trig_error <= 3'h0;
            trig_done  <= 3'h0;
        end
        else
        begin
            trig_error <= (trig_error & ~trig_enable_cleared) | err_set;
            trig_done  <= (trig_done & ~done_clr) | done_set;
        end
    end

    chk_version_capture: assert property (@(posedge clk) disable iff (!resetn)
        rx_msg.valid && rx_msg.version != exp_version |-> msg_drop && !capture_en)
        else $error("version mismatch not dropped");
    chk_domain_ignored: assert property (@(posedge clk) disable iff (!resetn)
        rx_msg.valid && !rx_msg.check_domain && rx_msg.version == exp_version |-> capture_en)
        else $error("domain not ignored");
    chk_domain_match: assert property (@(posedge clk) disable iff (!resetn)
        capture_en && rx_msg.check_domain |-> rx_msg.domain == exp_domain)
        else $error("domain mismatch captured");
    chk_index_write: assert property (@(posedge clk) disable iff (!resetn)
        wr && sel_idx |=> unit_sel.trig_sel == $past(wdata[1:0]) && index[15:12] == 4'h0)
        else $error("index not stored");
    chk_pin_stamp: assert property (@(posedge clk) disable iff (!resetn)
        wr && sel_idx |=> unit_sel.pin_sel == $past(wdata[16])
            && unit_sel.stamp_sel == $past(wdata[8]))
        else $error("pin or stamp pointer wrong");
    chk_window_route: assert property (@(posedge clk) disable iff (!resetn)
        (wr || rd) && in_win |-> (win_wr || win_rd))
        else $error("window access not routed");
    chk_error_set: assert property (@(posedge clk) disable iff (!resetn)
        err_set[0] |=> trig_error[0] ##0 irq || !irq_mask[3])
        else $error("error bit not set");
    chk_error_clear: assert property (@(posedge clk) disable iff (!resetn)
        trig_enable_cleared[1] && !err_set[1] |=> !trig_error[1])
        else $error("error bit not cleared");
    chk_done_w1c: assert property (@(posedge clk) disable iff (!resetn)
        wr && sel_st && wdata[2] && !done_set[2] |=> !trig_done[2])
        else $error("done bit not cleared");
    chk_read_zero: assert property (@(posedge clk) disable iff (!resetn)
        rd && sel_dv |=> rdata[31:12] == 20'h0)
        else $error("reserved bits not zero");
    chk_version_reset: assert property (@(posedge clk)
        $rose(resetn) |-> exp_version == `RST_VERSION)
        else $error("version reset wrong");

    chk_done_irq: assert property (@(posedge clk) disable iff (!resetn)
        trig_done[0] && irq_mask[0] |-> irq)
        else $error("done interrupt missing");
    chk_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
        !rd |=> rdata == 32'h0)
        else $error("read data without read");
    chk_status_rsvd: assert property (@(posedge clk) disable iff (!resetn)
        rd && sel_st |=> rdata[31:19] == 13'h0 && rdata[15:3] == 13'h0)
        else $error("status reserved bits not zero");

    cov_done_irq: cover property (@(posedge clk) disable iff (!resetn) done_set != 3'h0 ##1 irq);
    cov_err_clear: cover property (@(posedge clk) disable iff (!resetn)
        trig_error != 3'h0 ##1 trig_error == 3'h0);
    cov_win_read: cover property (@(posedge clk) disable iff (!resetn) win_rd);
    cov_drop:     cover property (@(posedge clk) disable iff (!resetn) msg_drop);
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk = 0, resetn = 0, wr = 0, rd = 0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    ptp_slice_pkg::ptp_msg_t rx_msg = '0;
    ptp_slice_pkg::unit_sel_t unit_sel;
    logic [2:0] late = 0, fired = 0, notify = 0, en_clr = 0;
    logic capture_en, msg_drop, win_wr, win_rd, irq;
    logic [3:0] ver = 4'h2;
    logic [7:0] dom = 8'h00;
    int n_errors = 0, n_tests = 0, seed = 64201, cycles = 0;
    ptp_filter_unit_index_trigger_status DUT (.clk(clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_msg(rx_msg),
        .capture_en(capture_en), .msg_drop(msg_drop), .trig_late(late), .trig_fired(fired),
        .trig_notify_enable(notify), .trig_enable_cleared(en_clr), .unit_sel(unit_sel),
        .win_wr(win_wr), .win_rd(win_rd), .irq(irq));
    initial forever #5 clk = ~clk;
    task finish_test;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_errors++;
            finish_test();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e, input string s);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 0;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e, input string s);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 0;
        #1 chk(rdata, e, s);
    endtask
    function logic cap_exp(ptp_slice_pkg::ptp_msg_t m);
        return m.valid && m.version == ver && (!m.check_domain || m.domain == dom);
    endfunction
    initial
    begin
        ptp_slice_pkg::ptp_msg_t m;
        logic [31:0] d;
        logic [1:0] c;
        logic [2:0] u;
        repeat (5) @(posedge clk);
        resetn <= 1;
        rchk(12'h518, 32'h200, "dv reset");
        rchk(12'h520, 32'h0, "idx reset");
        rchk(12'h524, 32'h0, "status reset");
        wreg(12'h520, 32'hffffffff);
        rchk(12'h520, 32'h000f0f03, "idx mask");
        for (int i = 0; i < 4; i++)
        begin
            c = i[1:0];
            wreg(12'h520, {15'h0, c[0], 7'h0, c[1], 6'h0, c});
            #1 chk(32'(unit_sel), {27'h0, c[0], c[1], c, c != 2'h3}, "unit sel");
        end
        $display("index test done");
        wreg(12'h518, 32'hffffffff);
        rchk(12'h518, 32'h00000fff, "dv mask");
        for (int i = 0; i < 150; i++)
        begin
            if (i % 25 == 0)
            begin
                d = $random(seed);
                {ver, dom} = d[11:0];
                wreg(12'h518, d);
                rchk(12'h518, {20'h0, ver, dom}, "dv rw");
            end
            d = $random(seed);
            m = d[13:0];
            if (d[20]) m.version = ver;
            if (d[21]) m.domain = dom;
            @(posedge clk) rx_msg <= m;
            #1 chk(capture_en, cap_exp(m), "capture");
            chk(msg_drop, m.valid && !cap_exp(m), "drop");
        end
        $display("filter test done");
        for (int i = 0; i < 12; i++)
        begin
            d = (i < 4) ? {20'h0, 12'h52b + 12'(i == 1) + 12'(i > 1) * 12'h87 + 12'(i == 3)}
                        : {20'h0, 12'h52c + 12'($random(seed) & 8'h7f)};
            @(posedge clk) {addr, wr} <= {d[11:0], 1'b1};
            #1 chk(win_wr, d[11:0] >= 12'h52c && d[11:0] <= 12'h5b3, "win wr");
            @(posedge clk) {wr, rd} <= 2'b01;
            #1 chk(win_rd, d[11:0] >= 12'h52c && d[11:0] <= 12'h5b3, "win rd");
            @(posedge clk) rd <= 0;
        end
        $display("window test done");
        for (int i = 0; i < 3; i++)
        begin
            u = 3'h1 << i;
            @(posedge clk) {notify, fired, late} <= {u, u, u};
            @(posedge clk) {fired, late} <= 6'h0;
            rchk(12'h524, {13'h0, u, 13'h0, u}, "set");
            chk(irq, 1'b0, "irq masked");
            wreg(12'h600, 32'h00070007);
            #1 chk(irq, 1'b1, "irq on");
            wreg(12'h524, {29'h0, u});
            rchk(12'h524, {13'h0, u, 16'h0}, "done w1c");
            @(posedge clk) en_clr <= u;
            @(posedge clk) en_clr <= 0;
            rchk(12'h524, 32'h0, "err clear");
            chk(irq, 1'b0, "irq off");
            wreg(12'h600, 32'h0);
            @(posedge clk) {notify, fired, late} <= {3'h0, u, u};
            @(posedge clk) {fired, late} <= 6'h0;
            rchk(12'h524, 32'h0, "no notify");
        end
        $display("trigger test done");
        finish_test();
    end
endmodule
